//--- design/debug_ctl_pkg.sv
// constants shared by the debug control, status and vector-catch block
package debug_ctl_pkg;

  // ****************************************************************
  // register selection on the scan register port
  // ****************************************************************
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_STATUS  = 2'h1;
  localparam logic [1:0] SEL_VCATCH  = 2'h2;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int CTRL_W   = 6;
  localparam int STAT_W   = 5;
  localparam int VCATCH_W = 8;
  localparam int DATA_W   = 8;

  // ****************************************************************
  // debug_control field positions
  // ****************************************************************
  localparam int CTRL_CMP_DISABLE = 5;
  localparam int CTRL_MONITOR     = 4;
  localparam int CTRL_STEP        = 3;
  localparam int CTRL_INT_INHIBIT = 2;
  localparam int CTRL_FORCE_RQ    = 1;
  localparam int CTRL_FORCE_ACK   = 0;

  // ****************************************************************
  // debug_status field positions
  // ****************************************************************
  localparam int STAT_REQUEST  = 1;
  localparam int STAT_ACK      = 0;
  localparam int STAT_INT_EN   = 2;
  localparam int STAT_SYS_DONE = 3;
  localparam int STAT_ISA      = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [5:0] CTRL_RESET    = 6'h10;
  localparam logic [7:0] VCATCH_RESET  = 8'h00;
  localparam logic       DISABLE_RESET = 1'h1;

  // ****************************************************************
  // vector decoding: index n catches byte address 4*n
  // ****************************************************************
  localparam int          VEC_LSB       = 2;
  localparam int          VEC_MSB       = 4;
  localparam logic [2:0]  VEC_PREFETCH  = 3'h3;
  localparam logic [2:0]  VEC_DATA_ABT  = 3'h4;

  // single-step sequencer states
  typedef enum logic [2:0] {
    STEP_IDLE  = 3'b001,
    STEP_RUN   = 3'b010,
    STEP_BREAK = 3'b100
  } step_state_e;

endpackage

//--- design/debug_control_status_vector_catch.sv
// debug control, debug status and vector catch logic of the on-chip debug unit
//
// Operation
// R1: control register holds six bits
// R2: write when read/write high, read when low
// R3: bit 5 disables comparators, resets to 0
// R4: reset-set disable flag cleared by chain-2 access
// R5: bit 4 monitor mode turns breaks into aborts
// R6: monitor select bit resets to one
// R7: bit 3 enables single-step hardware
// R8: leaving debug while stepping: one instruction, re-enter
// R9: debugger changes step bit only in debug
// R10: debugger never steps in monitor mode
// R11: interrupts inhibited by acknowledge or bit 2
// R12: bit 1 synchronised, ORed with external request
// R13: acknowledge output is core acknowledge OR bit 0
// R14: five-bit status register returned on read
// R15: status bits 1:0 synchronised request, acknowledge
// R16: status bit 2 is core interrupt enable
// R17: status bit 3 is system access complete
// R18: status bit 4 is compressed ISA state
// R19: caught exception acts like breakpoint on vector
// R20: bit 2 catches fetch from 0x8
// R21: only exception-entry fetches are caught
// R22: catch and step independent of comparators
// R23: monitor mode skips abort vector catches
// R24: catch bit n watches address 4*n
module debug_control_status_vector_catch
  import debug_ctl_pkg::*;
(
  input  wire logic                            clock_i,
  input  wire logic                            arst_n_i,
  input  wire logic                            reg_access_i,
  input  wire logic                            reg_write_i,
  input  wire logic [1:0]                      reg_select_i,
  input  wire logic [debug_ctl_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                            chain2_access_i,
  input  wire logic                            external_debug_request_i,
  input  wire logic                            core_debug_acknowledge_i,
  input  wire logic                            core_interrupt_enable_i,
  input  wire logic                            system_access_complete_i,
  input  wire logic                            compressed_isa_state_i,
  input  wire logic                            interrupt_i,
  input  wire logic                            fast_interrupt_i,
  input  wire logic                            fetch_valid_i,
  input  wire logic [31:0]                     fetch_addr_i,
  input  wire logic                            exception_entry_i,
  input  wire logic                            instr_executed_i,
  input  wire logic                            cmp_breakpoint_i,
  input  wire logic                            cmp_watchpoint_i,
  output logic      [debug_ctl_pkg::DATA_W-1:0] reg_rdata_o,
  output logic                                 comparators_disable_o,
  output logic                                 monitor_mode_o,
  output logic                                 debug_request_o,
  output logic                                 debug_acknowledge_o,
  output logic                                 interrupt_o,
  output logic                                 fast_interrupt_o,
  output logic                                 instruction_breakpoint_o,
  output logic                                 data_watchpoint_o,
  output logic                                 prefetch_abort_o,
  output logic                                 data_abort_o
);
  import debug_ctl_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [CTRL_W-1:0]   debug_control;
  logic [VCATCH_W-1:0] vector_catch;
  logic                disable_flag;
  logic                ext_rq_s1;
  logic                ext_rq_s2;
  logic                ctl_rq_s1;
  logic                ctl_rq_s2;
  logic                ack_sync;
  logic                ack_prev;
  logic [STAT_W-1:0]   debug_status;
  logic                wr_control;
  logic                wr_vcatch;
  logic                rd_access;
  logic                next_ack;
  logic                int_block;
  logic                cmp_enabled;
  logic                monitor;
  logic [2:0]          vec_index;
  logic                vec_area;
  logic                vec_hit;
  logic                vec_suppress;
  logic                catch_fire;
  logic                step_fire;
  step_state_e         step_state;
  step_state_e         next_step_state;

  // ****************************************************************
  // register port decode
  // ****************************************************************
  assign wr_control = reg_access_i & reg_write_i & (reg_select_i == SEL_CONTROL); // R2
  assign wr_vcatch  = reg_access_i & reg_write_i & (reg_select_i == SEL_VCATCH);
  assign rd_access  = reg_access_i & ~reg_write_i; // R2

  // ****************************************************************
  // control, vector catch and disable registers
  // ****************************************************************
  // control register, six bits, monitor mode set at reset
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      debug_control <= CTRL_RESET; // R6
    end else if (wr_control) begin
      debug_control <= reg_wdata_i[CTRL_W-1:0]; // R1
    end
  end

  // vector catch register
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vector_catch <= VCATCH_RESET;
    end else if (wr_vcatch) begin
      vector_catch <= reg_wdata_i;
    end
  end

  // comparator disable flag held from reset until chain 2 is used
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      disable_flag <= DISABLE_RESET; // R4
    end else if (chain2_access_i) begin
      disable_flag <= 1'b0; // R4
    end
  end

  // ****************************************************************
  // request synchronisers
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_rq_s1 <= 1'b0;
      ext_rq_s2 <= 1'b0;
      ctl_rq_s1 <= 1'b0;
      ctl_rq_s2 <= 1'b0;
    end else begin
      ext_rq_s1 <= external_debug_request_i;
      ext_rq_s2 <= ext_rq_s1;
      ctl_rq_s1 <= debug_control[CTRL_FORCE_RQ]; // R12
      ctl_rq_s2 <= ctl_rq_s1; // R12
    end
  end

  // ****************************************************************
  // acknowledge sampling
  // ****************************************************************
  // acknowledge sampled for status and for step sequencing
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_sync <= 1'b0;
      ack_prev <= 1'b0;
    end else begin
      ack_sync <= core_debug_acknowledge_i; // R15
      ack_prev <= ack_sync;
    end
  end

  // ****************************************************************
  // request, acknowledge and interrupt gating
  // ****************************************************************
  assign next_ack  = core_debug_acknowledge_i | debug_control[CTRL_FORCE_ACK]; // R13
  assign int_block = next_ack | debug_control[CTRL_INT_INHIBIT]; // R11

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      debug_request_o     <= 1'b0;
      debug_acknowledge_o <= 1'b0;
    end else begin
      debug_request_o     <= ctl_rq_s2 | ext_rq_s2; // R12
      debug_acknowledge_o <= next_ack; // R13
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      interrupt_o      <= 1'b0;
      fast_interrupt_o <= 1'b0;
    end else begin
      interrupt_o      <= interrupt_i & ~int_block; // R11
      fast_interrupt_o <= fast_interrupt_i & ~int_block; // R11
    end
  end

  // ****************************************************************
  // status register and read data
  // ****************************************************************
  always_comb begin
    debug_status                = '0;
    debug_status[STAT_REQUEST]  = ext_rq_s2; // R15
    debug_status[STAT_ACK]      = ack_sync; // R15
    debug_status[STAT_INT_EN]   = core_interrupt_enable_i; // R16
    debug_status[STAT_SYS_DONE] = system_access_complete_i; // R17
    debug_status[STAT_ISA]      = compressed_isa_state_i; // R18
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= '0;
    end else if (rd_access) begin
      unique case (reg_select_i)
        SEL_CONTROL: begin
          reg_rdata_o <= {{(DATA_W-CTRL_W){1'b0}}, debug_control}; // R2
        end
        SEL_STATUS: begin
          reg_rdata_o <= {{(DATA_W-STAT_W){1'b0}}, debug_status}; // R14
        end
        SEL_VCATCH: begin
          reg_rdata_o <= vector_catch;
        end
        default: begin
          reg_rdata_o <= '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // comparator enable and monitor mode
  // ****************************************************************
  assign cmp_enabled = ~debug_control[CTRL_CMP_DISABLE] & ~disable_flag; // R3 R4
  assign monitor     = debug_control[CTRL_MONITOR]; // R5

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      comparators_disable_o <= DISABLE_RESET | CTRL_RESET[CTRL_CMP_DISABLE]; // R3 R4
      monitor_mode_o        <= CTRL_RESET[CTRL_MONITOR]; // R6
    end else begin
      comparators_disable_o <= ~cmp_enabled; // R3
      monitor_mode_o        <= monitor; // R5
    end
  end

  // ****************************************************************
  // vector catch
  // ****************************************************************
  assign vec_index    = fetch_addr_i[VEC_MSB:VEC_LSB]; // R24
  assign vec_area     = (fetch_addr_i[31:VEC_MSB+1] == '0) &&
                        (fetch_addr_i[VEC_LSB-1:0] == '0);
  assign vec_suppress = monitor &&
                        ((vec_index == VEC_PREFETCH) || (vec_index == VEC_DATA_ABT)); // R23
  assign vec_hit      = vector_catch[vec_index] & vec_area; // R20 R24
  assign catch_fire   = fetch_valid_i & exception_entry_i & vec_hit & ~vec_suppress; // R19 R21

  // ****************************************************************
  // single-step sequencer
  // ****************************************************************
  always_comb begin
    next_step_state = step_state;
    unique case (step_state)
      STEP_IDLE: begin
        if (ack_prev && !ack_sync && debug_control[CTRL_STEP]) begin
          next_step_state = STEP_RUN; // R7 R8
        end
      end
      STEP_RUN: begin
        if (instr_executed_i) begin
          next_step_state = STEP_BREAK; // R8
        end
      end
      STEP_BREAK: begin
        if (ack_sync) begin
          next_step_state = STEP_IDLE; // R8
        end
      end
      default: begin
        next_step_state = STEP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      step_state <= STEP_IDLE;
    end else begin
      step_state <= next_step_state;
    end
  end

  assign step_fire = (step_state == STEP_BREAK) & ~ack_sync; // R8 R22

  // ****************************************************************
  // breakpoint, watchpoint and abort outputs
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      instruction_breakpoint_o <= 1'b0;
      data_watchpoint_o        <= 1'b0;
      prefetch_abort_o         <= 1'b0;
      data_abort_o             <= 1'b0;
    end else begin
      instruction_breakpoint_o <= catch_fire | step_fire | // R19 R20 R22
                                  (cmp_enabled & cmp_breakpoint_i & ~monitor); // R5
      data_watchpoint_o        <= cmp_enabled & cmp_watchpoint_i & ~monitor; // R5
      prefetch_abort_o         <= cmp_enabled & cmp_breakpoint_i & monitor; // R5
      data_abort_o             <= cmp_enabled & cmp_watchpoint_i & monitor; // R5
    end
  end

endmodule

//--- verification/debug_control_status_vector_catch_monitor.sv
// port assertions for the debug control, status and vector catch block
module debug_control_status_vector_catch_monitor (
  input wire logic                             clock_i, arst_n_i, reg_access_i, reg_write_i,
  input wire logic                             chain2_access_i, external_debug_request_i,
  input wire logic                             core_debug_acknowledge_i, interrupt_i,
  input wire logic                             fast_interrupt_i, fetch_valid_i, exception_entry_i,
  input wire logic                             instr_executed_i, cmp_breakpoint_i, cmp_watchpoint_i,
  input wire logic [debug_ctl_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic                             comparators_disable_o, monitor_mode_o,
  input wire logic                             debug_request_o, debug_acknowledge_o, interrupt_o,
  input wire logic                             fast_interrupt_o, instruction_breakpoint_o,
  input wire logic                             data_watchpoint_o, prefetch_abort_o, data_abort_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_irq_gate: assert property (interrupt_o |-> !debug_acknowledge_o && $past(interrupt_i))
    else $error("interrupt passed while gated");
  a_fiq_gate: assert property (fast_interrupt_o |-> !debug_acknowledge_o && $past(fast_interrupt_i))
    else $error("fast interrupt passed while gated");
  a_ack_follow: assert property (core_debug_acknowledge_i |=> debug_acknowledge_o)
    else $error("acknowledge output missed core acknowledge");
  a_req_sync: assert property (external_debug_request_i [*4] |-> debug_request_o)
    else $error("external request not passed on");
  a_catch_cause: assert property ($rose(instruction_breakpoint_o) |->
    $past(fetch_valid_i && exception_entry_i) || $past(cmp_breakpoint_i) || $past(instr_executed_i, 2))
    else $error("breakpoint without cause");
  a_monitor_abort: assert property (prefetch_abort_o |-> $past(cmp_breakpoint_i && monitor_mode_o))
    else $error("prefetch abort outside monitor mode");
  a_halt_watch: assert property (data_watchpoint_o |-> $past(cmp_watchpoint_i && !monitor_mode_o))
    else $error("watchpoint outside halt mode");
  a_cmp_off: assert property (cmp_breakpoint_i && comparators_disable_o && !$past(chain2_access_i)
    && !$past(reg_access_i) |=> !prefetch_abort_o)
    else $error("abort while comparators disabled");
  a_rdata_hold: assert property (!(reg_access_i && !reg_write_i) |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
endmodule
bind debug_control_status_vector_catch debug_control_status_vector_catch_monitor
  i_debug_control_status_vector_catch_monitor (.*);

//--- verification/core_model.sv
// behavioural processor core facing the debug block
module core_model (
  input  wire logic clock_i,
  input  wire logic arst_n_i,
  input  wire logic debug_request_i,
  input  wire logic breakpoint_i,
  input  wire logic restart_i,
  output logic      debug_ack_o,
  output logic      executed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      debug_ack_o <= 1'b0;
      phase <= 2'h0;
    end else if (debug_ack_o) begin
      debug_ack_o <= !restart_i;
      phase <= 2'h0;
    end else begin
      debug_ack_o <= debug_request_i | breakpoint_i;
      phase <= phase + 2'h1;
    end
  end
  // one instruction every fourth cycle while running
  assign executed_o = !debug_ack_o && phase == 2'h3;
endmodule

//--- verification/debug_control_status_vector_catch_bench.sv
// self-checking bench for the debug control, status and vector catch block
module debug_control_status_vector_catch_bench;
  import debug_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, arst_n_i, acc, wr, chain2, ext_rq, inten, sysd, isa, irq, fast_interrupt;
  logic        fv, exc, ack, exe, restart, dis, mon, rq, ack_o, irq_o, fiq_o, ibrk, wpt, pab, dab;
  logic [1:0]  sel, cmp;
  logic [7:0]  wd, rdata;
  logic [31:0] fa;
  int          err_count, n_tests, n;
  wire logic [7:0] lv = {2'h0, dis, mon, rq, ack_o, irq_o, fiq_o};
  wire logic [7:0] bk = {4'h0, ibrk, wpt, pab, dab};
  debug_control_status_vector_catch i_debug_control_status_vector_catch (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_access_i(acc), .reg_write_i(wr),
    .reg_select_i(sel), .reg_wdata_i(wd), .chain2_access_i(chain2),
    .external_debug_request_i(ext_rq), .core_debug_acknowledge_i(ack),
    .core_interrupt_enable_i(inten), .system_access_complete_i(sysd),
    .compressed_isa_state_i(isa), .interrupt_i(irq), .fast_interrupt_i(fast_interrupt),
    .fetch_valid_i(fv), .fetch_addr_i(fa), .exception_entry_i(exc), .instr_executed_i(exe),
    .cmp_breakpoint_i(cmp[0]), .cmp_watchpoint_i(cmp[1]), .reg_rdata_o(rdata),
    .comparators_disable_o(dis), .monitor_mode_o(mon), .debug_request_o(rq),
    .debug_acknowledge_o(ack_o), .interrupt_o(irq_o), .fast_interrupt_o(fiq_o),
    .instruction_breakpoint_o(ibrk), .data_watchpoint_o(wpt), .prefetch_abort_o(pab),
    .data_abort_o(dab));
  core_model i_core_model (.clock_i(clock_i), .arst_n_i(arst_n_i), .debug_request_i(rq),
    .breakpoint_i(ibrk), .restart_i(restart), .debug_ack_o(ack), .executed_o(exe));
  always #12.5 clock_i = ~clock_i;
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc_op(input logic w, input logic [1:0] s, input logic [7:0] d);
    acc = 1'b1;
    wr = w;
    sel = s;
    wd = d;
    @(negedge clock_i);
    acc = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    acc_op(1'b0, s, 8'h00);
    chk("read data", rdata, e);
  endtask
  task automatic stim(input logic [1:0] c, input logic [31:0] a, input logic x,
                      input logic [3:0] e);
    cmp = c;
    fv = (c == 2'h0);
    fa = a;
    exc = x;
    @(negedge clock_i);
    cmp = 2'h0;
    fv = 1'b0;
    exc = 1'b0;
    chk("break outputs", bk, {4'h0, e});
    @(negedge clock_i);
  endtask
  task automatic go;
    restart = 1'b1;
    @(negedge clock_i);
    restart = 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    {clock_i, arst_n_i, acc, wr, chain2, ext_rq, inten, sysd, isa, fv, exc, restart} = '0;
    {sel, cmp, wd, fa, err_count, n_tests, n} = '0;
    {irq, fast_interrupt} = 2'h3;
    repeat (8) @(negedge clock_i);
    arst_n_i = 1'b1;
    @(negedge clock_i);
    chk("levels", lv, 8'h33);
    rd(SEL_CONTROL, 8'h10);
    acc_op(1'b1, SEL_CONTROL, 8'hE5);
    rd(SEL_CONTROL, 8'h25);
    chk("levels", lv, 8'h24);
    acc_op(1'b1, SEL_STATUS, 8'hFF);
    rd(SEL_CONTROL, 8'h25);
    rd(2'h3, 8'h00);
    acc_op(1'b1, SEL_CONTROL, 8'h04);
    chk("levels", lv, 8'h20);
    acc_op(1'b1, SEL_CONTROL, 8'h00);
    chk("levels", lv, 8'h23);
    stim(2'h1, 32'h0, 1'b0, 4'h0);
    chain2 = 1'b1;
    @(negedge clock_i);
    chain2 = 1'b0;
    @(negedge clock_i);
    chk("levels", lv, 8'h03);
    for (n = 0; n < 8; n++) begin
      {isa, sysd, inten} = n[2:0];
      rd(SEL_STATUS, {3'h0, n[2:0], 2'h0});
    end
    acc_op(1'b1, SEL_CONTROL, 8'h10);
    stim(2'h1, 32'h0, 1'b0, 4'h2);
    stim(2'h2, 32'h0, 1'b0, 4'h1);
    acc_op(1'b1, SEL_CONTROL, 8'h30);
    stim(2'h3, 32'h0, 1'b0, 4'h0);
    acc_op(1'b1, SEL_CONTROL, 8'h00);
    stim(2'h2, 32'h0, 1'b0, 4'h4);
    stim(2'h1, 32'h0, 1'b0, 4'h8);
    acc_op(1'b1, SEL_VCATCH, 8'h04);
    stim(2'h0, 32'h8, 1'b1, 4'h8);
    stim(2'h0, 32'h8, 1'b0, 4'h0);
    stim(2'h0, 32'h4, 1'b1, 4'h0);
    acc_op(1'b1, SEL_VCATCH, 8'hFF);
    acc_op(1'b1, SEL_CONTROL, 8'h20);
    for (n = 0; n < 8; n++) begin
      stim(2'h0, {27'h0, n[2:0], 2'h0}, 1'b1, 4'h8);
    end
    acc_op(1'b1, SEL_CONTROL, 8'h30);
    stim(2'h0, 32'hC, 1'b1, 4'h0);
    stim(2'h0, 32'h10, 1'b1, 4'h0);
    stim(2'h0, 32'h8, 1'b1, 4'h8);
    go();
    acc_op(1'b1, SEL_CONTROL, 8'h02);
    repeat (5) @(negedge clock_i);
    chk("levels", lv, 8'h0C);
    rd(SEL_STATUS, 8'h1D);
    ext_rq = 1'b1;
    acc_op(1'b1, SEL_CONTROL, 8'h00);
    repeat (3) @(negedge clock_i);
    chk("levels", lv, 8'h0C);
    rd(SEL_STATUS, 8'h1F);
    ext_rq = 1'b0;
    acc_op(1'b1, SEL_CONTROL, 8'h08);
    repeat (4) @(negedge clock_i);
    go();
    n = 0;
    for (int i = 0; i < 40 && ack !== 1'b1; i++) begin
      @(negedge clock_i);
      if (exe === 1'b1) n++;
    end
    chk("steps", n[7:0], 8'h01);
    chk("reentry", {7'h0, ack}, 8'h01);
    acc_op(1'b1, SEL_CONTROL, 8'h00);
    go();
    complete_run();
  end
  initial begin
    repeat (3000) @(negedge clock_i);
    err_count++;
    complete_run();
  end
endmodule
